/* rtl/pnfc_defs.svh */
// register map, field positions and timing counts of the flash host
`ifndef PNFC_DEFS_SVH
`define PNFC_DEFS_SVH
`define PNFC_OFF_CTRL 8'h00
`define PNFC_OFF_ADDR 8'h04
`define PNFC_OFF_WDATA 8'h08
`define PNFC_OFF_STATUS 8'h0C
`define PNFC_OFF_CFG 8'h10
`define PNFC_CTRL_OP_LSB 0
`define PNFC_CTRL_GO 2
`define PNFC_CTRL_URGENT 3
`define PNFC_CTRL_POLL_LSB 4
`define PNFC_ADDR_W 23
`define PNFC_ADDR_BYTE_LSB 23
`define PNFC_ST_ENGINE_BUSY 0
`define PNFC_ST_DEV_BUSY 1
`define PNFC_ST_REFUSED 2
`define PNFC_ST_DONE 3
`define PNFC_ST_RDATA_LSB 16
`define PNFC_CFG_BYTE_MODE 0
`define PNFC_CFG_PROTECT_LOW 1
`define PNFC_CFG_RESET 32'h0000_0000
`define PNFC_AXI_OKAY 2'h0
`define PNFC_AXI_SLVERR 2'h2
`define PNFC_CLK_NS 10
`define PNFC_T_SETUP_NS 10
`define PNFC_T_WE_NS 50
`define PNFC_T_ACC_NS 70
`define PNFC_T_BUSY_NS 100
`define PNFC_T_RST_LOW_NS 500
`define PNFC_T_RST_REC_NS 200
`define PNFC_CYC(ns) (((ns) + `PNFC_CLK_NS - 1) / `PNFC_CLK_NS)
`define PNFC_SYNC_CYC 2
`endif

/* rtl/pnfc_pkg.sv */
// types shared by the flash host controller
package pnfc_pkg;
   typedef enum logic [2:0] {
      PNFC_IDLE = 3'h0,
      PNFC_SETUP = 3'h1,
      PNFC_STROBE = 3'h3,
      PNFC_HOLD = 3'h2,
      PNFC_POLL = 3'h6,
      PNFC_RST = 3'h7,
      PNFC_RECOV = 3'h5
   } pnfc_state_e;
   typedef enum logic [1:0] {
      PNFC_OP_READ = 2'h0,
      PNFC_OP_WRITE = 2'h1,
      PNFC_OP_POLL = 2'h2,
      PNFC_OP_RESET = 2'h3
   } pnfc_op_e;
   typedef enum logic [1:0] {
      PNFC_POLL_PIN = 2'h0,
      PNFC_POLL_TOGGLE = 2'h1,
      PNFC_POLL_DATA = 2'h2
   } pnfc_poll_e;
   typedef struct packed {
      logic [22:0] addr;
      logic ce_n;
      logic we_n;
      logic oe_n;
      logic byte_n;
      logic reset_n;
      logic protect_or_accel_pin;
   } pnfc_pins_s;
endpackage : pnfc_pkg

/* rtl/pnfc_host.sv */
// host controller driving a parallel nor flash from axi4-lite registers
//
// Design decisions made here: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
`include "pnfc_defs.svh"
module pnfc_host #(
   parameter int ADDR_W = `PNFC_ADDR_W,
   parameter int RST_LOW_CYC = `PNFC_CYC(`PNFC_T_RST_LOW_NS)
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output pnfc_pkg::pnfc_pins_s flash_pins,
   input wire logic [15:0] dq_in,
   output logic [15:0] dq_out,
   output logic [15:0] dq_oe_n,
   input wire logic operation_done_n
);
   import pnfc_pkg::*;

   localparam logic [7:0] SETUP_CYC = 8'(`PNFC_CYC(`PNFC_T_SETUP_NS));
   localparam logic [7:0] WE_CYC = 8'(`PNFC_CYC(`PNFC_T_WE_NS));
   // read data passes the two-stage synchroniser, so oe stays low longer
   localparam logic [7:0] RD_CYC =
      8'(`PNFC_CYC(`PNFC_T_ACC_NS) + `PNFC_SYNC_CYC);
   localparam logic [7:0] BUSY_CYC = 8'(`PNFC_CYC(`PNFC_T_BUSY_NS));
   localparam logic [15:0] REC_CYC = 16'(`PNFC_CYC(`PNFC_T_RST_REC_NS));

   function automatic logic [31:0] strobe_merge(input logic [31:0] old,
         input logic [31:0] nw, input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[8*i +: 8] = nw[8*i +: 8];
         end
      end
      return r;
   endfunction : strobe_merge

   // synchronisers for the asynchronous flash outputs
   logic [15:0] dq_m_q, dq_s_q;
   logic rdy_m_q, rdy_s_q;
   always_ff @(posedge aclk) begin
      dq_m_q <= dq_in;
      dq_s_q <= dq_m_q;
      rdy_m_q <= operation_done_n;
      rdy_s_q <= rdy_m_q;
   end
   wire dev_busy = !rdy_s_q;

   // register file
   logic [31:0] ctrl_q, addr_q, wdata_q, cfg_q;
   logic [7:0] awaddr_q;
   logic [31:0] wbus_q;
   logic [3:0] wstrb_q;
   logic done_q, refused_q;
   logic [15:0] rdata_q;
   pnfc_state_e st_q;
   logic [15:0] cnt_q;
   pnfc_op_e op_q;
   pnfc_poll_e poll_q;
   logic first_q, prev_tgl_q;
   pnfc_pins_s pins_q;
   logic [15:0] dq_out_q, dq_oe_n_q;

   wire commit = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
   wire hit_ctrl = awaddr_q == `PNFC_OFF_CTRL;
   wire hit_addr = awaddr_q == `PNFC_OFF_ADDR;
   wire hit_wdata = awaddr_q == `PNFC_OFF_WDATA;
   wire hit_status = awaddr_q == `PNFC_OFF_STATUS;
   wire hit_cfg = awaddr_q == `PNFC_OFF_CFG;
   wire w_mapped = hit_ctrl | hit_addr | hit_wdata | hit_status | hit_cfg;
   wire [31:0] ctrl_new = strobe_merge(ctrl_q, wbus_q, wstrb_q);
   wire go_req = commit && hit_ctrl && ctrl_new[`PNFC_CTRL_GO];
   wire pnfc_op_e new_op = pnfc_op_e'(ctrl_new[`PNFC_CTRL_OP_LSB +: 2]);
   wire urgent = ctrl_new[`PNFC_CTRL_URGENT];
   wire engine_idle = st_q == PNFC_IDLE;
   // only a non-urgent write is held off while the flash reports busy
   wire busy_block = dev_busy && new_op == PNFC_OP_WRITE && !urgent;
   wire start = go_req && engine_idle && !busy_block;
   wire refuse = go_req && !start;

   wire [31:0] status_word = {rdata_q, 12'h000, done_q, refused_q,
      dev_busy, !engine_idle};
   wire ar_hit_ctrl = s_axi_araddr == `PNFC_OFF_CTRL;
   wire ar_hit_addr = s_axi_araddr == `PNFC_OFF_ADDR;
   wire ar_hit_wdata = s_axi_araddr == `PNFC_OFF_WDATA;
   wire ar_hit_status = s_axi_araddr == `PNFC_OFF_STATUS;
   wire ar_hit_cfg = s_axi_araddr == `PNFC_OFF_CFG;
   wire r_mapped = ar_hit_ctrl | ar_hit_addr | ar_hit_wdata |
      ar_hit_status | ar_hit_cfg;
   wire [31:0] rd_mux = ar_hit_ctrl ? ctrl_q :
      ar_hit_addr ? addr_q :
      ar_hit_wdata ? wdata_q :
      ar_hit_status ? status_word :
      ar_hit_cfg ? cfg_q : 32'h0000_0000;

   // axi write channel: address and data taken in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `PNFC_AXI_OKAY;
         awaddr_q <= 8'h00;
         wbus_q <= 32'h0000_0000;
         wstrb_q <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            awaddr_q <= {s_axi_awaddr[7:2], 2'h0};
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wbus_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (commit) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= w_mapped ? `PNFC_AXI_OKAY : `PNFC_AXI_SLVERR;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= `PNFC_AXI_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_mux;
         s_axi_rresp <= r_mapped ? `PNFC_AXI_OKAY : `PNFC_AXI_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   // go bit is self clearing; other registers hold what software wrote
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_q <= 32'h0000_0000;
         addr_q <= 32'h0000_0000;
         wdata_q <= 32'h0000_0000;
         cfg_q <= `PNFC_CFG_RESET;
      end else if (commit) begin
         if (hit_ctrl) begin
            ctrl_q <= ctrl_new & ~(32'h1 << `PNFC_CTRL_GO);
         end
         if (hit_addr) begin
            addr_q <= strobe_merge(addr_q, wbus_q, wstrb_q);
         end
         if (hit_wdata) begin
            wdata_q <= strobe_merge(wdata_q, wbus_q, wstrb_q);
         end
         if (hit_cfg) begin
            cfg_q <= strobe_merge(cfg_q, wbus_q, wstrb_q);
         end
      end
   end

   wire byte_mode = cfg_q[`PNFC_CFG_BYTE_MODE];
   wire cnt_end = cnt_q == 16'h0001;
   wire write_op = op_q == PNFC_OP_WRITE;
   wire polling_status_bit = rdata_q[7]; // latched word, not the live bus
   wire toggling_status_bit = rdata_q[6];
   wire poll_hit = (poll_q == PNFC_POLL_TOGGLE) ?
      (!first_q && toggling_status_bit == prev_tgl_q) :
      (polling_status_bit == wdata_q[7]);
   // in byte mode dq15 is an address input and is driven in read and write cycles alike
   wire [15:0] cyc_oe_n = write_op ? 16'h0000 :
      (byte_mode ? 16'h7FFF : 16'hFFFF);
   wire [15:0] cyc_out = byte_mode ?
      {addr_q[`PNFC_ADDR_BYTE_LSB], wdata_q[14:0]} : wdata_q[15:0];

   // flash bus cycle engine
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_q <= PNFC_IDLE;
         cnt_q <= 16'h0000;
         op_q <= PNFC_OP_READ;
         poll_q <= PNFC_POLL_PIN;
         first_q <= 1'b0;
         prev_tgl_q <= 1'b0;
         done_q <= 1'b0;
         refused_q <= 1'b0;
         rdata_q <= 16'h0000;
         pins_q <= '{addr: '0, ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1,
            byte_n: 1'b1, reset_n: 1'b1, protect_or_accel_pin: 1'b1};
         dq_out_q <= 16'h0000;
         dq_oe_n_q <= 16'hFFFF;
      end else begin
         pins_q.byte_n <= !byte_mode;
         pins_q.protect_or_accel_pin <= !cfg_q[`PNFC_CFG_PROTECT_LOW];
         if (refuse) begin
            refused_q <= 1'b1;
         end else if (start) begin
            refused_q <= 1'b0;
         end
         case (st_q)
            PNFC_IDLE: begin
               if (start) begin
                  done_q <= 1'b0;
                  op_q <= new_op;
                  poll_q <= pnfc_poll_e'(ctrl_new[`PNFC_CTRL_POLL_LSB +: 2]);
                  first_q <= 1'b1;
                  if (new_op == PNFC_OP_RESET) begin
                     pins_q.reset_n <= 1'b0;
                     cnt_q <= 16'(RST_LOW_CYC);
                     st_q <= PNFC_RST;
                  end else if (new_op == PNFC_OP_POLL &&
                        ctrl_new[`PNFC_CTRL_POLL_LSB +: 2] == 2'h0) begin
                     cnt_q <= 16'(BUSY_CYC);
                     st_q <= PNFC_POLL;
                  end else begin
                     st_q <= PNFC_SETUP;
                     cnt_q <= 16'(SETUP_CYC);
                  end
               end
            end
            PNFC_SETUP: begin
               pins_q.addr <= addr_q[ADDR_W-1:0];
               pins_q.ce_n <= 1'b0;
               dq_out_q <= cyc_out;
               dq_oe_n_q <= cyc_oe_n;
               if (cnt_end && !pins_q.ce_n) begin
                  st_q <= PNFC_STROBE;
                  cnt_q <= write_op ? 16'(WE_CYC) : 16'(RD_CYC);
                  pins_q.we_n <= !write_op;
                  pins_q.oe_n <= write_op;
               end else if (!pins_q.ce_n) begin
                  cnt_q <= cnt_q - 16'h0001;
               end
            end
            PNFC_STROBE: begin
               if (cnt_end) begin
                  // flash latches address and data on the rising write edge
                  pins_q.we_n <= 1'b1;
                  pins_q.oe_n <= 1'b1;
                  st_q <= PNFC_HOLD;
                  if (!write_op) begin
                     rdata_q <= dq_s_q;
                  end
               end else begin
                  cnt_q <= cnt_q - 16'h0001;
               end
            end
            PNFC_HOLD: begin
               // chip select released between cycles lets the flash idle
               pins_q.ce_n <= 1'b1;
               dq_oe_n_q <= 16'hFFFF;
               first_q <= 1'b0;
               prev_tgl_q <= rdata_q[6];
               if (op_q == PNFC_OP_POLL && !poll_hit) begin
                  st_q <= PNFC_SETUP;
                  cnt_q <= 16'(SETUP_CYC);
               end else begin
                  st_q <= PNFC_IDLE;
                  done_q <= 1'b1;
               end
            end
            PNFC_POLL: begin
               // busy pin may lag the last write, so wait before trusting it
               if (!cnt_end) begin
                  cnt_q <= cnt_q - 16'h0001;
               end else if (!dev_busy) begin
                  st_q <= PNFC_IDLE;
                  done_q <= 1'b1;
               end
            end
            PNFC_RST: begin
               if (cnt_end) begin
                  pins_q.reset_n <= 1'b1;
                  cnt_q <= REC_CYC;
                  st_q <= PNFC_RECOV;
               end else begin
                  cnt_q <= cnt_q - 16'h0001;
               end
            end
            PNFC_RECOV: begin
               if (cnt_end) begin
                  st_q <= PNFC_IDLE;
                  done_q <= 1'b1;
               end else begin
                  cnt_q <= cnt_q - 16'h0001;
               end
            end
            default: begin
               st_q <= PNFC_IDLE;
            end
         endcase
      end
   end

   assign flash_pins = pins_q;
   assign dq_out = dq_out_q;
   assign dq_oe_n = dq_oe_n_q;
endmodule : pnfc_host

/* bench/pnfc_host_asserts.sv */
// bus and flash pin timing assertions for the flash host
`timescale 1ns/1ps
module pnfc_host_asserts #(
   parameter int RST_LOW_CYC = 50
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire pnfc_pkg::pnfc_pins_s flash_pins,
   input wire logic [15:0] dq_oe_n
);
   import pnfc_pkg::*;
   wire ce_n = flash_pins.ce_n;
   wire we_n = flash_pins.we_n;
   wire oe_n = flash_pins.oe_n;
   wire rst_n = flash_pins.reset_n;
   logic [15:0] rlow_q;
   // counts sampled low cycles of the flash reset pulse
   always_ff @(posedge aclk) begin
      if (!aresetn || rst_n) rlow_q <= 16'h0000;
      else rlow_q <= rlow_q + 16'h0001;
   end
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   property p_b_once; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
   endproperty
   a_b_once: assert property (p_b_once) else $error("bvalid stays");
   property p_r_once; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
   endproperty
   a_r_once: assert property (p_r_once) else $error("rvalid stays");
   property p_we_ce; !we_n |-> !ce_n && oe_n; endproperty
   a_we_ce: assert property (p_we_ce) else $error("bad write strobe");
   property p_oe_ce; !oe_n |-> !ce_n; endproperty
   a_oe_ce: assert property (p_oe_ce) else $error("bad read strobe");
   property p_we_len; $fell(we_n) |=> !we_n [*4] ##1 we_n; endproperty
   a_we_len: assert property (p_we_len) else $error("strobe width");
   property p_we_dq; !we_n |-> dq_oe_n[7:0] == 8'h00; endproperty
   a_we_dq: assert property (p_we_dq) else $error("data not driven");
   property p_release; $rose(we_n) |=> ce_n && dq_oe_n == 16'hFFFF;
   endproperty
   a_release: assert property (p_release) else $error("no release");
   property p_rst_len; $rose(rst_n) |-> int'(rlow_q) == RST_LOW_CYC;
   endproperty
   a_rst_len: assert property (p_rst_len) else $error("reset width");
   property p_rst_rec; $rose(rst_n) |-> ce_n [*8]; endproperty
   a_rst_rec: assert property (p_rst_rec) else $error("no recovery");
   property p_ce_lead; $fell(we_n) || $fell(oe_n) |-> !$past(ce_n);
   endproperty
   a_ce_lead: assert property (p_ce_lead) else $error("no setup");
   property p_byte_hi; !oe_n && !flash_pins.byte_n |-> dq_oe_n == 16'h7FFF;
   endproperty
   a_byte_hi: assert property (p_byte_hi) else $error("dq15 float");
   cover property (!oe_n && !flash_pins.byte_n);
   cover property ($fell(we_n));
   cover property ($rose(rst_n));
   cover property (s_axi_rvalid && s_axi_rready);
endmodule : pnfc_host_asserts

bind pnfc_host pnfc_host_asserts #(.RST_LOW_CYC(RST_LOW_CYC)) i_chk (
   .aclk(aclk), .aresetn(aresetn), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready), .flash_pins(flash_pins),
   .dq_oe_n(dq_oe_n));

/* bench/pnfc_flash_model.sv */
// behavioural nor flash answering the host's strobe cycles
`timescale 1ns/1ps
module pnfc_flash_model #(
   parameter int BUSY_NS = 600
) (
   input wire pnfc_pkg::pnfc_pins_s pins,
   input wire logic [15:0] dq_wire,
   output logic [15:0] dq_drv,
   output logic operation_done_n
);
   import pnfc_pkg::*;
   logic [15:0] mem [int];
   logic [15:0] last = 16'h0000;
   logic [1:0] arm = 2'h0;
   logic tog = 1'b0;
   int gen = 0;
   initial operation_done_n = 1'b1;
   initial dq_drv = 16'h5A5A;
   function automatic logic [15:0] rd(input int a);
      return mem.exists(a) ? mem[a] : 16'hFFFF;
   endfunction : rd
   // a0 arms a program, 80 an erase; the next write carries it out
   task automatic cmd(input int a, input logic [15:0] d);
      int g;
      logic [1:0] m;
      m = arm;
      arm = (d == 16'h00A0) ? 2'h1 : (d == 16'h0080) ? 2'h2 : 2'h0;
      if (m != 2'h0) begin
         arm = 2'h0;
         // protect pin guards sector 0 only while it is held low
         if (!pins.protect_or_accel_pin && a[21:15] == 0) begin
            return;
         end
         gen++;
         g = gen;
         last = d;
         operation_done_n = 1'b0;
         fork
            begin
               #(BUSY_NS * m);
               if (g == gen) begin
                  operation_done_n = 1'b1;
                  if (m == 2'h1) mem[a] = rd(a) & d;
                  else begin
                     foreach (mem[k]) begin
                        if (k[21:15] == a[21:15]) mem[k] = 16'hFFFF;
                     end
                  end
               end
            end
         join_none
      end
   endtask : cmd
   always @(posedge pins.we_n) begin
      if (!pins.ce_n && pins.reset_n) cmd(int'(pins.addr), dq_wire);
   end
   // aborting drops the pending result as well as busy
   always @(negedge pins.reset_n) begin
      gen++;
      arm = 2'h0;
      operation_done_n = 1'b1;
   end
   always @(negedge pins.oe_n) tog = ~tog;
   always @(pins or operation_done_n or tog) begin
      if (!pins.ce_n && !pins.oe_n) begin
         if (!operation_done_n) dq_drv = {8'h00, ~last[7], tog, 6'h00};
         else dq_drv = rd(int'(pins.addr));
      end else begin
         dq_drv = ~dq_drv;
      end
   end
endmodule : pnfc_flash_model

/* bench/tb_top.sv */
// self-checking bench for the flash host with a behavioural flash
`timescale 1ns/1ps
`include "pnfc_defs.svh"
module tb_top;
   import pnfc_pkg::*;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] awaddr = 8'h00;
   logic [7:0] araddr = 8'h00;
   logic [31:0] wdata = 32'h0000_0000;
   logic [3:0] wstrb = 4'hF;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, done_n;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata, st;
   logic [15:0] fl_drv, dq_out, dq_oe_n;
   wire [15:0] dq_bus = (~dq_oe_n & dq_out) | (dq_oe_n & fl_drv);
   pnfc_pins_s pins;
   logic [15:0] bm [int];
   int aq[$];
   int errors = 0, samples_checked = 0, cyc = 0;
   bit prot = 1'b0;
   logic [31:0] seed = 32'h89B70BAD;
   pnfc_host #(.RST_LOW_CYC(5)) i_dut (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .flash_pins(pins), .dq_in(dq_bus),
      .dq_out(dq_out), .dq_oe_n(dq_oe_n), .operation_done_n(done_n));
   // long busy keeps the refusal, urgent and abort checks inside one program
   pnfc_flash_model #(.BUSY_NS(1000)) i_flash (.pins(pins), .dq_wire(dq_bus),
      .dq_drv(fl_drv), .operation_done_n(done_n));
   always #5 aclk = ~aclk;
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 40000) begin
         errors++;
         finish_test();
      end
   end
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : rnd
   function automatic logic [15:0] ev(input int a);
      return bm.exists(a) ? bm[a] : 16'hFFFF;
   endfunction : ev
   task automatic chk(input string n, input logic [31:0] e,
      input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         errors++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic finish_test();
      $display("checks %0d errors %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : finish_test
   task automatic axw(input logic [7:0] a, input logic [31:0] d);
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while ((awvalid && !awready) || (wvalid && !wready));
      do @(posedge aclk); while (bvalid !== 1'b1);
      bready <= 1'b0;
   endtask : axw
   // leaves read data in st; rresp stands until the next read
   task automatic axr(input logic [7:0] a);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge aclk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge aclk); while (rvalid !== 1'b1);
      st = rdata;
      rready <= 1'b0;
   endtask : axr
   task automatic op(input int o, input int a, input int d, input int m);
      axw(`PNFC_OFF_ADDR, 32'(a));
      axw(`PNFC_OFF_WDATA, 32'(d));
      axw(`PNFC_OFF_CTRL, 32'(o + 4 + m));
      do axr(`PNFC_OFF_STATUS); while (st[0] === 1'b1);
   endtask : op
   task automatic prog(input int a, input int d, input int pm);
      op(1, 32'h555, 32'h00A0, 0);
      op(1, a, d, 0);
      op(2, a, d, pm * 16);
      chk("status", 32'h8, {28'h0, st[3:0]});
      if (!(prot && a[21:15] == 0)) bm[a] = ev(a) & d[15:0];
   endtask : prog
   task automatic fread(input int a);
      op(0, a, 0, 0);
      chk("read", {16'h0, ev(a)}, {16'h0, st[31:16]});
   endtask : fread
   initial begin
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      chk("idle pins", 32'h3F, {26'h0, pins[5:0]});
      axr(`PNFC_OFF_CFG);
      chk("cfg", `PNFC_CFG_RESET, st);
      axr(8'h20);
      chk("slverr", {30'h0, `PNFC_AXI_SLVERR}, {30'h0, rresp});
      axw(`PNFC_OFF_ADDR, 32'hFFFF_FFFF);
      wstrb <= 4'h3;
      axw(`PNFC_OFF_ADDR, 32'h0000_0000);
      wstrb <= 4'hF;
      axr(`PNFC_OFF_ADDR);
      chk("wstrb", 32'hFFFF_0000, st);
      axw(`PNFC_OFF_CFG, 32'h1);
      // pins follow cfg one edge after the write lands
      @(posedge aclk);
      chk("byte", 32'h0, {31'h0, pins.byte_n});
      op(0, 32'h200, 0, 0);
      chk("byte read", 32'h7FFF, {16'h0, st[31:16]});
      axw(`PNFC_OFF_CFG, 32'h2);
      prot = 1'b1;
      @(posedge aclk);
      chk("prot", 32'h0, {31'h0, pins.protect_or_accel_pin});
      prog(32'h100, 32'h1234, 0);
      fread(32'h100);
      axw(`PNFC_OFF_CFG, 32'h0);
      prot = 1'b0;
      aq.push_back(32'h3FFFFF);
      for (int i = 0; i < 6; i++) begin
         aq.push_back(int'(rnd() % 32'h3F8000) + 32'h8000);
      end
      foreach (aq[i]) prog(aq[i], int'(rnd() & 32'hFFFF), i % 3);
      foreach (aq[i]) fread(aq[i]);
      op(1, 32'h555, 32'h0080, 0);
      op(1, aq[1], 32'h0030, 0);
      op(2, aq[1], 0, 16);
      foreach (bm[k]) if (k[21:15] == aq[1][21:15]) bm[k] = 16'hFFFF;
      fread(aq[1]);
      fread(aq[2]);
      op(1, 32'h555, 32'h00A0, 0);
      op(1, 32'h10000, 32'h00FF, 0);
      op(1, 32'h555, 32'h00B0, 0);
      chk("refused", 32'hE, {28'h0, st[3:0]});
      op(1, 32'h555, 32'h00B0, 8);
      chk("urgent", 32'hA, {28'h0, st[3:0]});
      op(3, 0, 0, 8);
      chk("aborted", 32'h8, {28'h0, st[3:0]});
      fread(32'h10000);
      finish_test();
   end
endmodule : tb_top
